// ==== core/smbsa_pkg.sv ====
// Constants, types and helpers for the strapped-address two-wire slave port
// Operation
// RULE_01: Act only as slave; never create start or stop; follow master clock.
// RULE_02: Transfers are nine-clock units: eight bits MSB first, then acknowledge.
// RULE_03: SDA changes only while SCL low, except master start and stop.
// RULE_04: SDA falling while SCL high is a start, beginning a transfer.
// RULE_05: SDA rising while SCL high is a stop; slave returns idle.
// RULE_06: Acknowledge each received byte by holding SDA low for ninth clock.
// RULE_07: Master leaves SDA high after last read byte, then sends stop.
// RULE_08: Strap enable high at first communication locks address 0101110.
// RULE_09: Enable low, select low 2C; select high 2D; enable high 2E.
// RULE_10: Latch strap address at first transaction whose top five bits are 01011.
// RULE_11: Shared enable and PWM pin starts as undriven input for strap sampling.
// RULE_12: After first transaction completes, shared pins return to fan functions.
// RULE_13: Start is followed by address and direction; acknowledge only own address.
// RULE_14: Direction 0: first following byte loads pointer and is acknowledged.
// RULE_15: Pointer naming no implemented register abandons the operation.
// RULE_16: Pointer persists across transactions for later reads.
// RULE_17: Master writes pointer byte first, then data, ending with stop.
// RULE_18: Bytes after pointer set without repeated start are written to register.
// RULE_19: After acknowledging a read address, drive data from next clock.
// RULE_20: One or two data bytes; new-register read uses pointer set, restart.
// RULE_21: Reset master forces bus reset holding a line low over 35 ms.
// RULE_22: Bus reset returns interface state machine to idle.
// RULE_23: SCL low beyond 25 to 35 ms resets machine and releases SDA.
// RULE_24: Drive SDA only low; oversample SCL and SDA through synchronisers.
// RULE_25: Timeout counter on internal clock, cleared while SCL is high.
package smbsa_pkg;

  // Addresses chosen by the straps, and the five-bit prefix they share
  localparam logic [6:0] ADDR_SEL_LOW   = 7'h2C;
  localparam logic [6:0] ADDR_SEL_HIGH  = 7'h2D;
  localparam logic [6:0] ADDR_DEFAULT   = 7'h2E;
  localparam logic [4:0] ADDR_PREFIX    = 5'h0B;

  // Bit positions inside one nine-clock unit
  localparam logic [3:0] BIT_FIRST      = 4'h0;
  localparam logic [3:0] BIT_LAST       = 4'h7;
  localparam logic [3:0] BIT_ACK        = 4'h8;

  // Reset values and idle answers
  localparam logic [7:0] PTR_RST        = 8'h00;
  localparam logic [7:0] IDLE_BYTE      = 8'hFF;

  // Bus-low timeout, least figure taken so the reset never comes late
  localparam int TOUT_MIN_MS    = 25;
  localparam int TOUT_MAX_MS    = 35;
  localparam int NS_PER_MS      = 1000000;
  localparam int LINK_PERIOD_NS = 160;
  localparam int TOUT_CYC       = (TOUT_MIN_MS * NS_PER_MS + LINK_PERIOD_NS - 1)
                                  / LINK_PERIOD_NS;

  typedef enum {
    ST_IDLE, ST_ADDR, ST_PTR, ST_WDAT, ST_RDAT, ST_IGN
  } smbsa_state_type;

  // Register access request towards the register file
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } smbsa_req_type;

  // Address selected by the two straps
  function automatic logic [6:0] smbsa_strap_addr(input logic en, input logic sel);
    if (en) begin
      return ADDR_DEFAULT;
    end
    return sel ? ADDR_SEL_HIGH : ADDR_SEL_LOW;
  endfunction

  // Three-stage edge test used for every crossing toggle
  function automatic logic smbsa_chg(input logic a, input logic b);
    return a ^ b;
  endfunction

endpackage

// ==== core/smbsa_port.sv ====
// Two-wire slave port with strapped address, pointer and register access
`timescale 1ns/1ps
`default_nettype none

module smbsa_port #(
  parameter int           TOUT_CYCLES = smbsa_pkg::TOUT_CYC,
  parameter logic [255:0] PTR_VALID   = {256{1'b1}}
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    link_clk,
  input  wire logic                    scl_in,
  input  wire logic                    sda_in,
  output logic                         sda_o,
  output logic                         sda_oe,
  input  wire logic                    addr_strap_en,
  output logic                         fan_drive_out_c_o,
  output logic                         fan_drive_out_c_oe,
  input  wire logic                    fan_speed_in_d,
  input  wire logic                    fan_pwm_level,
  output logic                         fan_speed_level,
  output logic                         pins_normal,
  output smbsa_pkg::smbsa_req_type     reg_req,
  output logic                         reg_wr_stb,
  input  wire logic [7:0]              reg_rd_data
);
  import smbsa_pkg::*;

  // Link domain state
  logic            scl_s1, scl_s2, scl_s3;
  logic            sda_s1, sda_s2, sda_s3;
  logic            sen_s1, sen_s2;
  logic            ssel_s1, ssel_s2;
  logic            rack_s1, rack_s2, rack_s3;
  logic [31:0]     tcnt_r;
  smbsa_state_type st_r;
  logic [3:0]      bit_r;
  logic [7:0]      sh_r;
  logic [7:0]      tx_r;
  logic            sda_oe_r;
  logic            rw_r;
  logic            mack_r;
  logic            locked_r;
  logic [6:0]      own_addr_r;
  logic [7:0]      ptr_r;
  logic            ptr_ok_r;
  logic            rd_req_tgl_r;
  logic            wr_tgl_r;
  logic [7:0]      wr_data_r;
  logic [7:0]      rd_word_r;
  logic            free_r;
  logic            sta_hold_r;

  // Core domain state
  logic            rreq_s1, rreq_s2, rreq_s3;
  logic            wreq_s1, wreq_s2, wreq_s3;
  logic            free_s1, free_s2;
  logic            tach_s1, tach_s2;
  logic            rd_pend_r;
  logic            rd_ack_tgl_r;
  logic [7:0]      rd_hold_r;
  smbsa_req_type   req_r;
  logic            wr_stb_r;
  logic            fan_oe_r;
  logic            tach_r;
  logic            pins_r;

  logic            scl_rise, scl_fall, start_c, stop_c, tout_hit;
  logic [6:0]      strap_addr;
  logic [6:0]      cand_addr;
  logic [7:0]      rd_byte;

  // Bus line synchronisers; first stage feeds only the second
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
    end else begin
      scl_s1 <= scl_in;  // RULE_24
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= sda_in;  // RULE_24
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
    end
  end

  // Strap pins and read-answer toggle into the link domain
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      sen_s1  <= 1'b0;
      sen_s2  <= 1'b0;
      ssel_s1 <= 1'b0;
      ssel_s2 <= 1'b0;
      rack_s1 <= 1'b0;
      rack_s2 <= 1'b0;
      rack_s3 <= 1'b0;
    end else begin
      sen_s1  <= addr_strap_en;
      sen_s2  <= sen_s1;
      ssel_s1 <= fan_speed_in_d;
      ssel_s2 <= ssel_s1;
      rack_s1 <= rd_ack_tgl_r;
      rack_s2 <= rack_s1;
      rack_s3 <= rack_s2;
    end
  end

  // Edge and condition detection on synchronised lines
  assign scl_rise = scl_s2 & ~scl_s3;
  assign scl_fall = ~scl_s2 & scl_s3;
  assign start_c  = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;  // RULE_04
  assign stop_c   = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;  // RULE_05
  assign tout_hit = (tcnt_r == 32'(TOUT_CYCLES - 1));

  // Address from straps until locked, locked value afterwards
  assign strap_addr = smbsa_strap_addr(sen_s2, ssel_s2);  // RULE_09
  assign cand_addr  = locked_r ? own_addr_r : strap_addr;
  // Unimplemented pointer reads answer with a released line
  assign rd_byte    = ptr_ok_r ? rd_word_r : IDLE_BYTE;  // RULE_15

  // Clock-low timeout, saturates so it fires once per stuck period
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      tcnt_r <= '0;
    end else if (scl_s2) begin
      tcnt_r <= '0;  // RULE_25
    end else if (tcnt_r != 32'(TOUT_CYCLES)) begin
      tcnt_r <= tcnt_r + 32'h1;  // RULE_25
    end
  end

  // Read data word, taken only after the answer toggle has crossed
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      rd_word_r <= IDLE_BYTE;
    end else if (smbsa_chg(rack_s2, rack_s3)) begin
      rd_word_r <= rd_hold_r;
    end
  end

  // Protocol engine: SDA only ever pulled low, changed on SCL falls or released on timeout
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      st_r         <= ST_IDLE;
      bit_r        <= BIT_FIRST;
      sh_r         <= '0;
      tx_r         <= IDLE_BYTE;
      sda_oe_r     <= 1'b0;  // RULE_01
      rw_r         <= 1'b0;
      mack_r       <= 1'b0;
      locked_r     <= 1'b0;
      own_addr_r   <= ADDR_DEFAULT;
      ptr_r        <= PTR_RST;
      ptr_ok_r     <= 1'b1;
      rd_req_tgl_r <= 1'b0;
      wr_tgl_r     <= 1'b0;
      wr_data_r    <= '0;
      free_r       <= 1'b0;
      sta_hold_r   <= 1'b0;
    end else if (tout_hit) begin
      st_r       <= ST_IDLE;  // RULE_22 RULE_23
      bit_r      <= BIT_FIRST;
      sda_oe_r   <= 1'b0;  // RULE_23
      sta_hold_r <= 1'b0;
    end else if (start_c) begin
      st_r       <= ST_ADDR;  // RULE_04 RULE_13
      bit_r      <= BIT_FIRST;
      sda_oe_r   <= 1'b0;
      sta_hold_r <= 1'b1;  // RULE_04
    end else if (stop_c) begin
      st_r       <= ST_IDLE;  // RULE_05
      sda_oe_r   <= 1'b0;
      sta_hold_r <= 1'b0;
      if (locked_r) begin
        free_r <= 1'b1;  // RULE_12
      end
    end else if (scl_rise) begin
      // Sample data while SCL is high
      if (bit_r != BIT_ACK) begin
        sh_r <= {sh_r[6:0], sda_s2};  // RULE_02
      end else begin
        mack_r <= ~sda_s2;  // RULE_07
      end
    end else if (scl_fall && sta_hold_r) begin
      // Fall that ends the start hold carries no bit; counting it would lose the LSB
      sta_hold_r <= 1'b0;  // RULE_04
    end else if (scl_fall && st_r != ST_IDLE && st_r != ST_IGN) begin
      if (bit_r < BIT_LAST) begin
        bit_r <= bit_r + 4'h1;  // RULE_02
        if (st_r == ST_RDAT) begin
          tx_r     <= {tx_r[6:0], 1'b1};
          sda_oe_r <= ~tx_r[6];  // RULE_03
        end
      end else if (bit_r == BIT_LAST) begin
        // Eighth bit done: decide acknowledge for the ninth clock
        bit_r    <= BIT_ACK;
        sda_oe_r <= 1'b0;
        unique case (st_r)
          ST_ADDR: begin
            if (!locked_r && sh_r[7:3] == ADDR_PREFIX) begin
              locked_r   <= 1'b1;  // RULE_08 RULE_10
              own_addr_r <= strap_addr;  // RULE_10
            end
            if (sh_r[7:1] == cand_addr) begin
              sda_oe_r <= 1'b1;  // RULE_13 RULE_06
              rw_r     <= sh_r[0];
              if (sh_r[0]) begin
                rd_req_tgl_r <= ~rd_req_tgl_r;  // RULE_16
              end
            end else begin
              st_r <= ST_IGN;  // RULE_13
            end
          end
          ST_PTR: begin
            ptr_r    <= sh_r;  // RULE_14
            ptr_ok_r <= PTR_VALID[sh_r];  // RULE_15
            sda_oe_r <= 1'b1;  // RULE_14 RULE_06
          end
          ST_WDAT: begin
            if (ptr_ok_r) begin
              sda_oe_r  <= 1'b1;  // RULE_06
              wr_data_r <= sh_r;  // RULE_18
              wr_tgl_r  <= ~wr_tgl_r;  // RULE_18
            end else begin
              st_r <= ST_IGN;  // RULE_15
            end
          end
          ST_RDAT: begin
            sda_oe_r <= 1'b0;  // RULE_07
          end
          default: begin
            st_r <= ST_IGN;
          end
        endcase
      end else begin
        // Ninth clock done: release and start the next unit
        bit_r    <= BIT_FIRST;
        sda_oe_r <= 1'b0;
        unique case (st_r)
          ST_ADDR: begin
            if (rw_r) begin
              st_r     <= ST_RDAT;  // RULE_19
              tx_r     <= rd_byte;
              sda_oe_r <= ~rd_byte[7];  // RULE_19
            end else begin
              st_r <= ST_PTR;  // RULE_14
            end
          end
          ST_PTR: begin
            st_r <= ptr_ok_r ? ST_WDAT : ST_IGN;  // RULE_15 RULE_18
          end
          ST_WDAT: begin
            st_r <= ST_WDAT;  // RULE_18 RULE_20
          end
          ST_RDAT: begin
            if (mack_r) begin
              tx_r     <= rd_byte;  // RULE_16
              sda_oe_r <= ~rd_byte[7];
            end else begin
              st_r <= ST_IGN;  // RULE_07
            end
          end
          default: begin
            st_r <= ST_IGN;
          end
        endcase
      end
    end
  end

  // Link toggles, release flag and tach pin into the core domain
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rreq_s1 <= 1'b0;
      rreq_s2 <= 1'b0;
      rreq_s3 <= 1'b0;
      wreq_s1 <= 1'b0;
      wreq_s2 <= 1'b0;
      wreq_s3 <= 1'b0;
      free_s1 <= 1'b0;
      free_s2 <= 1'b0;
      tach_s1 <= 1'b0;
      tach_s2 <= 1'b0;
    end else begin
      rreq_s1 <= rd_req_tgl_r;
      rreq_s2 <= rreq_s1;
      rreq_s3 <= rreq_s2;
      wreq_s1 <= wr_tgl_r;
      wreq_s2 <= wreq_s1;
      wreq_s3 <= wreq_s2;
      free_s1 <= free_r;
      free_s2 <= free_s1;
      tach_s1 <= fan_speed_in_d;
      tach_s2 <= tach_s1;
    end
  end

  // Register access: pointer and write byte are stable while toggles cross
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_r        <= '0;
      wr_stb_r     <= 1'b0;
      rd_pend_r    <= 1'b0;
      rd_hold_r    <= IDLE_BYTE;
      rd_ack_tgl_r <= 1'b0;
    end else begin
      wr_stb_r <= 1'b0;
      if (smbsa_chg(wreq_s2, wreq_s3)) begin
        req_r    <= '{wr: 1'b1, addr: ptr_r, data: wr_data_r};  // RULE_18
        wr_stb_r <= 1'b1;
      end else if (smbsa_chg(rreq_s2, rreq_s3)) begin
        req_r     <= '{wr: 1'b0, addr: ptr_r, data: 8'h00};  // RULE_16
        rd_pend_r <= 1'b1;
      end else if (rd_pend_r) begin
        // Register file answers one cycle after the address
        rd_hold_r    <= reg_rd_data;
        rd_ack_tgl_r <= ~rd_ack_tgl_r;
        rd_pend_r    <= 1'b0;
      end
    end
  end

  // Shared fan pins: undriven until the transaction that locked the address has ended
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fan_oe_r <= 1'b0;  // RULE_11
      tach_r   <= 1'b0;
      pins_r   <= 1'b0;
    end else begin
      pins_r   <= free_s2;  // RULE_12
      fan_oe_r <= free_s2 & ~fan_pwm_level;  // RULE_11 RULE_12
      tach_r   <= free_s2 & tach_s2;  // RULE_12
    end
  end

  // Open-drain data constant low; only the enable moves
  assign sda_o              = 1'b0;  // RULE_24
  assign sda_oe             = sda_oe_r;  // RULE_24
  assign fan_drive_out_c_o  = 1'b0;
  assign fan_drive_out_c_oe = fan_oe_r;
  assign fan_speed_level    = tach_r;
  assign pins_normal        = pins_r;
  assign reg_req            = req_r;
  assign reg_wr_stb         = wr_stb_r;

endmodule

`default_nettype wire

// ==== testbench/smbsa_host_model.sv ====
// Bus master model that drives the two-wire clock and data
`timescale 1ns/1ps
`default_nettype none
module smbsa_host_model (
  input  wire logic clk,
  input  wire logic sda_wire,
  output logic      scl_low,
  output logic      sda_low
);
  // Idle bus, both lines left to their pull-ups
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // Quarter step of 320 ns; SCL low three quarters, past the port's three-cycle answer
  task automatic wait_q(input int n);
    repeat (n * 80) @(posedge clk);
    #1;
  endtask
  // One bit: data set while SCL low, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    wait_q(2);
    scl_low = 1'b0;
    wait_q(1);
    r = sda_wire;
    wait_q(1);
    scl_low = 1'b1;
    wait_q(1);
  endtask
  task automatic start;
    sda_low = 1'b1;
    wait_q(2);
    scl_low = 1'b1;
    wait_q(1);
  endtask
  task automatic restart;
    sda_low = 1'b0;
    wait_q(3);
    scl_low = 1'b0;
    wait_q(2);
    start();
  endtask
  task automatic stop;
    sda_low = 1'b1;
    wait_q(3);
    scl_low = 1'b0;
    wait_q(2);
    sda_low = 1'b0;
    wait_q(3);
  endtask
  // Eight bits MSB first, then the line left free for acknowledge
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rd_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(!more, r);
  endtask
endmodule
`default_nettype wire

// ==== testbench/smbsa_port_monitor.sv ====
// Concurrent checks on the slave port's pins
`timescale 1ns/1ps
`default_nettype none
module smbsa_port_monitor #(
  parameter int TOUT_CYCLES = 200
) (
  input wire logic                     clk,
  input wire logic                     rst,
  input wire logic                     link_clk,
  input wire logic                     scl_in,
  input wire logic                     sda_in,
  input wire logic                     sda_o,
  input wire logic                     sda_oe,
  input wire logic                     addr_strap_en,
  input wire logic                     fan_drive_out_c_o,
  input wire logic                     fan_drive_out_c_oe,
  input wire logic                     fan_speed_in_d,
  input wire logic                     fan_pwm_level,
  input wire logic                     fan_speed_level,
  input wire logic                     pins_normal,
  input wire smbsa_pkg::smbsa_req_type reg_req,
  input wire logic                     reg_wr_stb,
  input wire logic [7:0]               reg_rd_data
);
  import smbsa_pkg::*;
  int unsigned low_r;
  // SCL low time in link cycles, with slack for the synchroniser
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      low_r <= 0;
    end else begin
      low_r <= scl_in ? 0 : low_r + 1;
    end
  end
  property p_low_only;
    @(posedge link_clk) disable iff (rst) sda_o == 1'b0;
  endproperty
  a_low_only: assert property (p_low_only) else $error("data driven high");
  property p_sda_hold;
    @(posedge link_clk) disable iff (rst) $changed(sda_oe) |-> !scl_in;
  endproperty
  a_sda_hold: assert property (p_sda_hold) else $error("data moved, clock high");
  property p_tout;
    @(posedge link_clk) disable iff (rst) low_r > TOUT_CYCLES + 6 |-> !sda_oe;
  endproperty
  a_tout: assert property (p_tout) else $error("data held past timeout");
  property p_oe_gate;
    @(posedge clk) disable iff (rst) !pins_normal |-> !fan_drive_out_c_oe;
  endproperty
  a_oe_gate: assert property (p_oe_gate) else $error("strap pin driven");
  property p_oe_follow;
    @(posedge clk) disable iff (rst)
      $past(pins_normal) |-> fan_drive_out_c_oe == !$past(fan_pwm_level);
  endproperty
  a_oe_follow: assert property (p_oe_follow) else $error("pwm not passed");
  property p_spd_gate;
    @(posedge clk) disable iff (rst) !pins_normal |-> !fan_speed_level;
  endproperty
  a_spd_gate: assert property (p_spd_gate) else $error("tach before release");
  property p_kept;
    @(posedge clk) disable iff (rst) pins_normal |=> pins_normal;
  endproperty
  a_kept: assert property (p_kept) else $error("pins went back");
  property p_wr_pulse;
    @(posedge clk) disable iff (rst) reg_wr_stb |=> !reg_wr_stb;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("long write strobe");
  property p_wr_kind;
    @(posedge clk) disable iff (rst) reg_wr_stb |-> reg_req.wr;
  endproperty
  a_wr_kind: assert property (p_wr_kind) else $error("strobe on read");
  property p_pwm_low;
    @(posedge clk) disable iff (rst) fan_drive_out_c_o == 1'b0;
  endproperty
  a_pwm_low: assert property (p_pwm_low) else $error("fan pin driven high");
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench for the strapped-address slave port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import smbsa_pkg::*;
  logic clk = 1'b0, link_clk = 1'b0, rst = 1'b1;
  logic en_pull = 1'b1, sel = 1'b0, pwm = 1'b1, ack;
  logic scl_low, sda_low, sda_o, sda_oe, fan_oe, spd, normal, wr_stb;
  logic [7:0] d;
  smbsa_req_type req, last_wr;
  int fails = 0, n_compared = 0, wr_cnt = 0, cyc = 0;
  // Open-drain wires resolved against their pull-ups
  wire logic scl_w = !scl_low;
  wire logic sda_w = !(sda_low | sda_oe);
  wire logic strap_w = en_pull & !fan_oe;
  wire logic [7:0] rd_data = req.addr ^ 8'h5A;
  always #2 clk = !clk;
  // Link clock offset so its edges never meet the core clock's
  initial begin
    #0.7;
    forever #80 link_clk = !link_clk;
  end
  smbsa_port #(.TOUT_CYCLES(100), .PTR_VALID(~(256'h1 << 8'hF0))) uut (
    .clk(clk), .rst(rst), .link_clk(link_clk), .scl_in(scl_w), .sda_in(sda_w),
    .sda_o(sda_o), .sda_oe(sda_oe), .addr_strap_en(strap_w),
    .fan_drive_out_c_o(), .fan_drive_out_c_oe(fan_oe), .fan_speed_in_d(sel),
    .fan_pwm_level(pwm), .fan_speed_level(spd), .pins_normal(normal),
    .reg_req(req), .reg_wr_stb(wr_stb), .reg_rd_data(rd_data));
  smbsa_host_model host (.clk(clk), .sda_wire(sda_w), .scl_low(scl_low), .sda_low(sda_low));
  // Record each write handed to the register file
  always @(posedge clk) begin
    if (wr_stb === 1'b1) begin
      wr_cnt++;
      last_wr = req;
    end
  end
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 150000) begin
      fails++;
      $display("unexpected at %0t: run too long", $time);
      tally_and_finish();
    end
  end
  task automatic check(input logic [16:0] got, input logic [16:0] exp, input string w);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h want %h", $time, w, got, exp);
    end
  endtask
  task automatic xfer(input logic [7:0] b, input logic exp, input string w);
    host.wr_byte(b, ack);
    check(ack, exp, w);
  endtask
  // Long enough to cover three link clock edges
  task automatic do_reset;
    rst = 1'b1;
    repeat (128) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (400) @(posedge clk);
    #1;
  endtask
  task automatic s_straps;
    logic [6:0] a [3] = '{ADDR_SEL_LOW, ADDR_SEL_HIGH, ADDR_DEFAULT};
    for (int i = 0; i < 3; i++) begin
      do_reset();
      en_pull = i[1];
      sel = i[0];
      host.start();
      xfer(8'hA0, 1'b0, "foreign");
      host.stop();
      check(normal, 1'b0, "no lock");
      check(fan_oe, 1'b0, "strap idle");
      host.start();
      xfer({a[i], 1'b0}, 1'b1, "strap addr");
      host.stop();
      check(normal, 1'b1, "released");
    end
  endtask
  task automatic s_write;
    host.start();
    xfer(8'h5C, 1'b1, "addr w");
    xfer(8'h05, 1'b1, "ptr");
    xfer(8'hA5, 1'b1, "data");
    host.stop();
    check(17'(wr_cnt), 17'h1, "writes");
    check(last_wr, {1'b1, 8'h05, 8'hA5}, "wr req");
    host.start();
    xfer(8'h58, 1'b0, "other addr");
    host.stop();
  endtask
  task automatic s_read;
    host.start();
    xfer(8'h5C, 1'b1, "addr w");
    xfer(8'h07, 1'b1, "ptr");
    host.restart();
    xfer(8'h5D, 1'b1, "addr r");
    host.rd_byte(1'b0, d);
    host.stop();
    check(d, 8'h5D, "rd");
    check(17'(wr_cnt), 17'h1, "no write");
  endtask
  // Bus held low mid-read, then the port must serve a fresh read
  task automatic s_timeout;
    host.start();
    xfer(8'h5D, 1'b1, "addr r");
    host.wait_q(2);
    check(sda_oe, 1'b1, "msb out");
    host.wait_q(60);
    check(sda_oe, 1'b0, "timeout");
    host.stop();
    host.start();
    xfer(8'h5D, 1'b1, "addr r");
    host.rd_byte(1'b1, d);
    check(d, 8'h5D, "rd1");
    host.rd_byte(1'b0, d);
    check(d, 8'h5D, "rd2");
    host.stop();
  endtask
  task automatic s_badptr;
    host.start();
    xfer(8'h5C, 1'b1, "addr w");
    xfer(8'hF0, 1'b1, "bad ptr");
    xfer(8'h11, 1'b0, "bad data");
    host.stop();
    host.start();
    xfer(8'h5D, 1'b1, "addr r");
    host.rd_byte(1'b0, d);
    host.stop();
    check(d, 8'hFF, "bad rd");
    check(17'(wr_cnt), 17'h1, "no write");
  endtask
  task automatic s_fan;
    sel = 1'b1;
    pwm = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    check(spd, 1'b1, "tach");
    check(fan_oe, 1'b1, "pwm low");
    pwm = 1'b1;
  endtask
  task automatic tally_and_finish;
    if (fails == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    s_straps();
    s_write();
    s_read();
    s_timeout();
    s_badptr();
    s_fan();
    tally_and_finish();
  end
endmodule
bind smbsa_port smbsa_port_monitor #(.TOUT_CYCLES(TOUT_CYCLES)) u_mon (
  .clk(clk), .rst(rst), .link_clk(link_clk), .scl_in(scl_in), .sda_in(sda_in),
  .sda_o(sda_o), .sda_oe(sda_oe), .addr_strap_en(addr_strap_en),
  .fan_drive_out_c_o(fan_drive_out_c_o), .fan_drive_out_c_oe(fan_drive_out_c_oe),
  .fan_speed_in_d(fan_speed_in_d), .fan_pwm_level(fan_pwm_level),
  .fan_speed_level(fan_speed_level), .pins_normal(pins_normal),
  .reg_req(reg_req), .reg_wr_stb(reg_wr_stb), .reg_rd_data(reg_rd_data));
`default_nettype wire
